// ==== rtl/mft_pkg.sv ====
package mft_pkg;

    // -------------------------------------------------------------------
    // register indices (byte address = index * 4)
    // -------------------------------------------------------------------
    localparam logic [11:0] REG_CSR_IDX    = 12'h008;
    localparam logic [11:0] REG_CNT_IDX    = 12'h009;
    localparam logic [11:0] REG_WDT_IDX    = 12'hFF0;
    localparam int          ADDR_W         = 14;

    // -------------------------------------------------------------------
    // control/status field positions and reset value
    // -------------------------------------------------------------------
    localparam int          CSR_OVF_FLAG   = 7;
    localparam int          CSR_PER_FLAG   = 6;
    localparam int          CSR_OVF_EN     = 5;
    localparam int          CSR_PER_EN     = 4;
    localparam int          CSR_OVF_ACK    = 3;
    localparam int          CSR_PER_ACK    = 2;
    localparam int          CSR_RATE_HI    = 1;
    localparam int          CSR_RATE_LO    = 0;
    localparam logic [1:0]  RATE_RESET     = 2'h3;
    localparam int          WDT_CLR_BIT    = 0;

    // -------------------------------------------------------------------
    // chain geometry and timing counts
    // -------------------------------------------------------------------
    localparam int          PRE_W          = 2;
    localparam logic [1:0]  PRE_LAST       = 2'h3;
    localparam int          CNT_W          = 8;
    localparam logic [7:0]  CNT_LAST       = 8'hFF;
    localparam int          HI_W           = 7;
    localparam int          TAP_LO         = 3;
    localparam int          WDT_W          = 3;
    localparam logic [2:0]  WDT_LAST       = 3'h7;
    localparam int          DLY_W          = 12;
    localparam logic [11:0] POR_SHORT_CYC  = 12'h0E0;
    localparam logic [11:0] POR_LONG_CYC   = 12'hFE0;

    // -------------------------------------------------------------------
    // bus responses
    // -------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        MFT_ST_RUN   = 3'b001,
        MFT_ST_HOLD  = 3'b010,
        MFT_ST_DELAY = 3'b100
    } mft_state_t;

    typedef struct packed {
        logic       ovf_irq_enable;
        logic       periodic_irq_enable;
        logic [1:0] periodic_rate_sel;
    } mft_ctrl_t;

    typedef struct packed {
        logic [7:0] cnt8;
        logic [6:0] hi;
        logic       ovf;
    } mft_chain_t;

endpackage : mft_pkg

// ==== rtl/mft_chain.sv ====
`timescale 1ns/1ps
`default_nettype none

module mft_chain (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               run,
    input  wire logic               clear,
    output var mft_pkg::mft_chain_t chain
);

    logic [mft_pkg::PRE_W-1:0] pre_reg;
    logic [mft_pkg::CNT_W-1:0] cnt_reg;
    logic [mft_pkg::HI_W-1:0]  hi_reg;
    logic                      ovf_reg;
    logic                      step;
    logic                      wrap;

    // -------------------------------------------------------------------
    // divide by four, eight-bit stage, seven-bit stage
    // -------------------------------------------------------------------
    assign step = run && (pre_reg == mft_pkg::PRE_LAST);                   // R1
    assign wrap = step && (cnt_reg == mft_pkg::CNT_LAST);                  // R4

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin                                       // R10
            pre_reg <= '0;
            cnt_reg <= '0;
            hi_reg  <= '0;
            ovf_reg <= 1'b0;
        end else begin
            if (run) begin
                pre_reg <= pre_reg + 2'h1;
            end
            if (step) begin
                cnt_reg <= cnt_reg + 8'h01;                                // R1
            end
            if (wrap) begin
                hi_reg <= hi_reg + 7'h01;                                  // R5
            end
            ovf_reg <= wrap;
        end
    end

    assign chain = '{cnt8: cnt_reg, hi: hi_reg, ovf: ovf_reg};

endmodule : mft_chain

`default_nettype wire

// ==== rtl/mft_timer.sv ====
// Notes on behaviour
// R1 - timer clock divided by four steps an eight-bit counter
// R2 - chain runs on the free clock, also during wait or halt
// R3 - eight-bit count readable anytime at index 0x09, zero after reset
// R4 - overflow flag sets on 0xFF to 0x00 wrap, every 1024 clocks
// R5 - eight-bit wrap clocks a seven-bit counter, top four stages are taps
// R6 - rate select picks 16384..131072, reset selects slowest
// R7 - software clears watchdog before changing rate select
// R8 - periodic flag sets when selected tap goes active
// R9 - power-on: chain runs 224 or 4064 cycles, then cleared, then counts
// R10 - external reset clears the whole chain
// R11 - watchdog divides periodic tap by eight, time-out raises internal reset
// R12 - software writes zero to bit 0 at index 0xFF0 to prevent time-out
// R13 - watchdog clear resets only the divide-by-eight stage
// R14 - control/status at index 0x08, acknowledge bits 2 and 3 read zero
// R15 - flags read-only, cleared only by writing one to own acknowledge or by reset
// R16 - interrupt while a flag and its enable are both set
// R17 - reset clears flags and enables, clear enable blocks interrupt
// R18 - acknowledge bits unaffected by reset, always read zero
// R19 - stop clears timer, stabilising delay on exit, then clear and count
// R20 - status bit layout 7 down to 0 as fixed
// R21 - flag set is a one-clock event, set wins over acknowledge
`timescale 1ns/1ps
`default_nettype none

module mft_timer #(
    parameter bit WDT_ENABLE = 1'b1,
    parameter bit POR_LONG   = 1'b0
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [mft_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [mft_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        stop_req,
    output logic                             timer_irq,
    output logic                             wdt_reset,
    output logic                             por_busy
);

    localparam logic [mft_pkg::DLY_W-1:0] DLY_CYC =
        POR_LONG ? mft_pkg::POR_LONG_CYC : mft_pkg::POR_SHORT_CYC;

    // -------------------------------------------------------------------
    // address decode helper
    // -------------------------------------------------------------------
    function automatic logic reg_hit(input logic [mft_pkg::ADDR_W-1:0] addr,
                                     input logic [11:0]                idx);
        reg_hit = (addr[mft_pkg::ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction : reg_hit

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    mft_pkg::mft_state_t          state_reg;
    mft_pkg::mft_state_t          state_next;
    mft_pkg::mft_ctrl_t           ctrl_reg;
    mft_pkg::mft_chain_t          chain;
    logic [mft_pkg::DLY_W-1:0]    dly_reg;
    logic [mft_pkg::WDT_W-1:0]    wdt_reg;
    logic                         ovf_flag_reg;
    logic                         periodic_flag_reg;
    logic                         tap_d_reg;
    logic                         wdt_reset_reg;
    logic                         aw_held_reg;
    logic                         w_held_reg;
    logic [mft_pkg::ADDR_W-1:0]   awaddr_reg;
    logic [31:0]                  wdata_reg;
    logic [3:0]                   wstrb_reg;
    logic                         bvalid_reg;
    logic [1:0]                   bresp_reg;
    logic                         rvalid_reg;
    logic [1:0]                   rresp_reg;
    logic [31:0]                  rdata_reg;
    logic                         soft_rst;
    logic                         st_run;
    logic                         st_hold;
    logic                         st_delay;
    logic                         dly_done;
    logic                         chain_run;
    logic                         chain_clr;
    logic                         tap;
    logic                         per_tick;
    logic                         wdt_fire;
    logic                         wdt_clr;
    logic                         do_wr;
    logic                         do_rd;
    logic                         wr_csr;
    logic                         wr_cnt;
    logic                         wr_wdt;
    logic                         rd_csr;
    logic                         rd_cnt;
    logic                         rd_wdt;
    logic                         ovf_ack_wr;
    logic                         per_ack_wr;
    logic [7:0]                   csr_view;

    // -------------------------------------------------------------------
    // mode sequencing: power-on delay, stop hold, run
    // -------------------------------------------------------------------
    assign soft_rst  = !aresetn || wdt_reset_reg;                          // R11
    assign st_run    = (state_reg == mft_pkg::MFT_ST_RUN);
    assign st_hold   = (state_reg == mft_pkg::MFT_ST_HOLD);
    assign st_delay  = (state_reg == mft_pkg::MFT_ST_DELAY);
    assign dly_done  = st_delay && (dly_reg == DLY_CYC - 12'h001);         // R9
    assign chain_run = st_run || st_delay;                                 // R2
    assign chain_clr = st_hold || dly_done || wdt_fire;                    // R9 R19

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mft_pkg::MFT_ST_RUN: begin
                if (stop_req) begin
                    state_next = mft_pkg::MFT_ST_HOLD;                     // R19
                end
            end
            mft_pkg::MFT_ST_HOLD: begin
                if (!stop_req) begin
                    state_next = mft_pkg::MFT_ST_DELAY;                    // R19
                end
            end
            mft_pkg::MFT_ST_DELAY: begin
                if (dly_done) begin
                    state_next = mft_pkg::MFT_ST_RUN;                      // R9
                end
            end
            default: state_next = mft_pkg::MFT_ST_DELAY;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (soft_rst) begin
            state_reg <= mft_pkg::MFT_ST_DELAY;                            // R9
            dly_reg   <= '0;
        end else begin
            state_reg <= state_next;
            dly_reg   <= st_delay && !dly_done ? dly_reg + 12'h001 : 12'h000;
        end
    end

    // -------------------------------------------------------------------
    // counter chain
    // -------------------------------------------------------------------
    mft_chain u_chain (
        .aclk    (aclk),
        .aresetn (!soft_rst),
        .run     (chain_run),
        .clear   (chain_clr),
        .chain   (chain)
    );

    // -------------------------------------------------------------------
    // periodic tap, watchdog
    // -------------------------------------------------------------------
    assign tap      = chain.hi[mft_pkg::TAP_LO + ctrl_reg.periodic_rate_sel]; // R5 R6
    assign per_tick = st_run && tap && !tap_d_reg;                         // R8
    assign wdt_fire = WDT_ENABLE && per_tick && (wdt_reg == mft_pkg::WDT_LAST); // R11
    assign wdt_clr  = wr_wdt && !wdata_reg[mft_pkg::WDT_CLR_BIT];          // R12

    always_ff @(posedge aclk) begin
        if (soft_rst) begin
            tap_d_reg     <= 1'b0;
            wdt_reg       <= '0;
            wdt_reset_reg <= 1'b0;
        end else begin
            tap_d_reg     <= tap;
            wdt_reset_reg <= wdt_fire;                                     // R11
            if (wdt_clr) begin
                wdt_reg <= '0;                                             // R13
            end else if (per_tick && !st_hold) begin
                wdt_reg <= wdt_reg + 3'h1;                                 // R11
            end
        end
    end

    // -------------------------------------------------------------------
    // flags, enables, rate select
    // -------------------------------------------------------------------
    assign ovf_ack_wr = wr_csr && wdata_reg[mft_pkg::CSR_OVF_ACK];         // R15
    assign per_ack_wr = wr_csr && wdata_reg[mft_pkg::CSR_PER_ACK];         // R15

    always_ff @(posedge aclk) begin
        if (soft_rst) begin
            ovf_flag_reg      <= 1'b0;                                     // R17
            periodic_flag_reg <= 1'b0;                                     // R17
            ctrl_reg          <= '{ovf_irq_enable: 1'b0,
                                   periodic_irq_enable: 1'b0,
                                   periodic_rate_sel: mft_pkg::RATE_RESET}; // R6
        end else begin
            if (st_run && chain.ovf) begin
                ovf_flag_reg <= 1'b1;                                      // R4 R21
            end else if (ovf_ack_wr) begin
                ovf_flag_reg <= 1'b0;
            end
            if (per_tick) begin
                periodic_flag_reg <= 1'b1;                                 // R8 R21
            end else if (per_ack_wr) begin
                periodic_flag_reg <= 1'b0;
            end
            if (wr_csr) begin
                ctrl_reg.ovf_irq_enable      <= wdata_reg[mft_pkg::CSR_OVF_EN];
                ctrl_reg.periodic_irq_enable <= wdata_reg[mft_pkg::CSR_PER_EN];
                ctrl_reg.periodic_rate_sel   <=
                    wdata_reg[mft_pkg::CSR_RATE_HI:mft_pkg::CSR_RATE_LO]; // R6 R7
            end
        end
    end

    assign timer_irq = (ovf_flag_reg && ctrl_reg.ovf_irq_enable) ||
                       (periodic_flag_reg && ctrl_reg.periodic_irq_enable); // R16
    assign wdt_reset = wdt_reset_reg;
    assign por_busy  = !st_run;

    // acknowledge positions always read zero
    assign csr_view = {ovf_flag_reg, periodic_flag_reg,
                       ctrl_reg.ovf_irq_enable, ctrl_reg.periodic_irq_enable,
                       2'h0, ctrl_reg.periodic_rate_sel};                  // R14 R18 R20

    // -------------------------------------------------------------------
    // AXI4-Lite write path
    // -------------------------------------------------------------------
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign do_wr  = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_csr = do_wr && wstrb_reg[0] && reg_hit(awaddr_reg, mft_pkg::REG_CSR_IDX); // R14
    assign wr_cnt = do_wr && reg_hit(awaddr_reg, mft_pkg::REG_CNT_IDX);
    assign wr_wdt = do_wr && wstrb_reg[0] && reg_hit(awaddr_reg, mft_pkg::REG_WDT_IDX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= mft_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (reg_hit(awaddr_reg, mft_pkg::REG_CSR_IDX) || wr_cnt ||
                                reg_hit(awaddr_reg, mft_pkg::REG_WDT_IDX)) ?
                               mft_pkg::RESP_OKAY : mft_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // -------------------------------------------------------------------
    // AXI4-Lite read path
    // -------------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign do_rd  = s_axi_arvalid && !rvalid_reg;
    assign rd_csr = reg_hit(s_axi_araddr, mft_pkg::REG_CSR_IDX);
    assign rd_cnt = reg_hit(s_axi_araddr, mft_pkg::REG_CNT_IDX);
    assign rd_wdt = reg_hit(s_axi_araddr, mft_pkg::REG_WDT_IDX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= mft_pkg::RESP_OKAY;
            rdata_reg  <= '0;
        end else if (do_rd) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= (rd_csr || rd_cnt || rd_wdt) ?
                          mft_pkg::RESP_OKAY : mft_pkg::RESP_SLVERR;
            rdata_reg  <= rd_csr ? {24'h000000, csr_view} :
                          rd_cnt ? {24'h000000, chain.cnt8} : 32'h00000000; // R3
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (soft_rst);

    sequence s_wdt_last_tick;
        WDT_ENABLE && per_tick && (wdt_reg == mft_pkg::WDT_LAST) && !wdt_clr;
    endsequence

    sequence s_long_hold;
        st_hold [*2];
    endsequence

    a_reset_values: assert property (                                      // R6
        $past(soft_rst) |-> ctrl_reg.periodic_rate_sel == 2'h3 && !ovf_flag_reg
                            && !periodic_flag_reg && !timer_irq)
        else $error("control state wrong after reset");

    a_ovf_flag_set: assert property (                                      // R21
        st_run && chain.ovf |=> ovf_flag_reg)
        else $error("overflow flag missed");

    a_flag_keeps: assert property (                                        // R15
        periodic_flag_reg && !per_ack_wr && !wdt_fire |=> periodic_flag_reg)
        else $error("periodic flag lost without acknowledge");

    a_irq_blocked: assert property (                                       // R17
        !ctrl_reg.ovf_irq_enable && !ctrl_reg.periodic_irq_enable |-> !timer_irq)
        else $error("interrupt without enable");

    a_count_step: assert property (                                        // R1
        st_run && $past(st_run) && !$past(chain_clr) && $changed(chain.cnt8)
        |-> (chain.cnt8 == $past(chain.cnt8) + 8'h01)
            ##1 ($stable(chain.cnt8) || $past(chain_clr)) [*3])
        else $error("prescaled count stepped wrongly");

    a_ack_reads_zero: assert property (                                    // R18
        do_rd && rd_csr |=> s_axi_rvalid && s_axi_rdata[3:2] == 2'h0)
        else $error("acknowledge bits read nonzero");

    a_wdt_clear: assert property (                                         // R13
        wdt_clr && !per_tick && !chain_clr
        |=> wdt_reg == 3'h0 && (chain.ovf || $stable(chain.hi)))
        else $error("watchdog clear misbehaved");

    a_wdt_timeout: assert property (                                       // R11
        @(posedge aclk) disable iff (!aresetn) s_wdt_last_tick |=> wdt_reset)
        else $error("watchdog time-out without reset");

    a_stop_clears: assert property (                                       // R19
        s_long_hold |-> chain.cnt8 == 8'h00 && chain.hi == 7'h00)
        else $error("chain not cleared in stop");

    a_run_from_zero: assert property (                                     // R9
        $rose(st_run) |-> chain.cnt8 == 8'h00 && $past(dly_reg) == DLY_CYC - 12'h001)
        else $error("power-on delay length or clear wrong");

endmodule : mft_timer

`default_nettype wire

// ==== test/mft_timer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mft_timer_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, stop_req = 1'b0;
    logic [13:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, timer_irq, wdt_reset, por_busy;
    logic [1:0]  bresp, rresp, r;
    int          mismatches = 0, n_checks = 0, cyc = 0, n;
    localparam logic [13:0] CSR = {mft_pkg::REG_CSR_IDX, 2'h0};
    localparam logic [13:0] CNT = {mft_pkg::REG_CNT_IDX, 2'h0};
    localparam logic [13:0] WDT = {mft_pkg::REG_WDT_IDX, 2'h0};
    mft_timer mft_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .stop_req(stop_req), .timer_irq(timer_irq), .wdt_reset(wdt_reset),
        .por_busy(por_busy));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            final_report();
        end
    end
    // -------------------------------------------------------------------
    // bus tasks, entered just after a rising edge
    // -------------------------------------------------------------------
    task automatic wr(input logic [13:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw_t, w_t, b_t;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
    endtask : wr
    task automatic rd(input logic [13:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar_t, r_t;
        araddr <= a;
        arvalid <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
        end
    endtask : rd
    task automatic chk_rd(input logic [13:0] a, input logic [31:0] e);
        rd(a, d, r);
        `CHK(d, e)
        `CHK(r, mft_pkg::RESP_OKAY)
    endtask : chk_rd
    task automatic wait_lvl(input logic lvl, output int c);
        c = 0;
        @(negedge aclk);
        while (por_busy !== lvl && c < 20000) begin
            @(negedge aclk);
            c++;
        end
        @(posedge aclk);
    endtask : wait_lvl
    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_por_ovf;
        int c1;
        wait_lvl(1'b0, n);
        `CHK((n >= 222 && n <= 227), 1'b1)
        chk_rd(CSR, 32'h0000_0003);
        `CHK(timer_irq, 1'b0)
        rd(CNT, d, r);
        `CHK((d < 32'h8), 1'b1)
        c1 = d;
        repeat (40) @(posedge aclk);
        rd(CNT, d, r);
        `CHK((((d - c1) & 32'hFF) >= 10 && ((d - c1) & 32'hFF) <= 12), 1'b1)
        repeat (1050) @(posedge aclk);
        chk_rd(CSR, 32'h0000_0083);
        `CHK(timer_irq, 1'b0)
        wr(CSR, 32'h0000_00E3, r);
        chk_rd(CSR, 32'h0000_00A3);
        `CHK(timer_irq, 1'b1)
        wr(CSR, 32'h0000_002B, r);
        chk_rd(CSR, 32'h0000_0023);
        `CHK(timer_irq, 1'b0)
    endtask : t_por_ovf
    task automatic t_bus;
        rd(14'h0000, d, r);
        `CHK(r, mft_pkg::RESP_SLVERR)
        rd(CSR + 14'h1, d, r);
        `CHK(r, mft_pkg::RESP_SLVERR)
        wr(CNT, 32'h0000_00FF, r);
        `CHK(r, mft_pkg::RESP_OKAY)
        wr(WDT, 32'h0000_0000, r);
        `CHK(r, mft_pkg::RESP_OKAY)
        `CHK(wdt_reset, 1'b0)
    endtask : t_bus
    task automatic t_periodic;
        wr(WDT, 32'h0000_0000, r);
        `CHK(r, mft_pkg::RESP_OKAY)
        wr(CSR, 32'h0000_0010, r);
        n = 0;
        while (timer_irq !== 1'b1 && n < 17000) begin
            @(negedge aclk);
            n++;
        end
        @(posedge aclk);
        `CHK(timer_irq, 1'b1)
        chk_rd(CSR, 32'h0000_00D0);
        wr(CSR, 32'h0000_0014, r);
        chk_rd(CSR, 32'h0000_0090);
    endtask : t_periodic
    task automatic t_stop;
        stop_req <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK(por_busy, 1'b1)
        chk_rd(CNT, 32'h0000_0000);
        stop_req <= 1'b0;
        wait_lvl(1'b0, n);
        `CHK((n >= 222 && n <= 228), 1'b1)
    endtask : t_stop
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_por_ovf();
        t_bus();
        t_periodic();
        t_stop();
        final_report();
    end
endmodule : mft_timer_bench
`default_nettype wire
